// *** hdl/umspi_pkg.sv ***
// Purpose: Shared constants for the master SPI operating mode block
// Assumes: One 20 MHz clock, no register bus
// Notes: Mode field encodings and frame figures live here
package umspi_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned DIV_W = 12;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_MSPI = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int unsigned BUF_DEPTH = 2;
endpackage : umspi_pkg

// *** hdl/umspi_buf2.sv ***
// Purpose: Two-entry valid/ready buffer in the byte path
// Assumes: Synchronous inputs, one clock
// Notes: Full and empty are exact; in_ready drops only when both slots hold data
`timescale 1ns/1ns
module umspi_buf2 #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic rd;
    logic [1:0] cnt;
  } umspi_buf_s;
  umspi_buf_s st_ff, nxt_st;
  logic push, pop;
  assign in_ready = st_ff.cnt != 2'h2;
  assign out_valid = st_ff.cnt != 2'h0;
  assign out_data = st_ff.mem[st_ff.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.rd ^ st_ff.cnt[0]] = in_data;
    end
    if (pop) begin
      nxt_st.rd = ~st_ff.rd;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      nxt_st.cnt = 2'h0;
      nxt_st.rd = 1'b0;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  empty_never_overfilled_a: assert property (@(posedge mclk) disable iff (rst) st_ff.cnt <= 2'h2)
    else $error("buffer count above two");
endmodule : umspi_buf2

// *** hdl/umspi_master.sv ***
// Purpose: Master SPI operating mode of a serial transceiver
// Assumes: Inputs synchronous to mclk; software keeps the clock pin an output
// Notes: Two-entry buffers on both transmit and receive paths give double buffering
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Mode field 3 selects master SPI
// - Parity and recovery logic off here
// - One shared controller drives both shifters
// - Pin override and interrupts unchanged
// - Same register places, changed bit meanings
// - Clock only generated internally, driven out
// - Bit rate is clock over 2(div+1)
// - Divisor is 12 bits from two halves
// - Fastest clock is half system clock
// - Next byte queued while current shifts
// - Full duplex on three wires
// - LSB or MSB first selectable
// - Mode number is polarity then phase
// - Sample and setup on opposite edges
// - Frame is exactly eight data bits
// - Each accepted data write starts one transfer
// - Frame, overrun, parity flags read zero
module umspi_master
  import umspi_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] operating_mode_select_field,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic bit_order_select,
  input wire logic transmitter_enable_bit,
  input wire logic receiver_enable_bit,
  input wire logic clock_pin_direction_bit,
  input wire logic [3:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  input wire logic baud_divisor_low_wr,
  input wire logic [7:0] tx_data,
  input wire logic tx_write,
  output logic tx_buffer_empty,
  output logic tx_complete,
  input wire logic tx_complete_clr,
  output logic [7:0] rx_data,
  output logic rx_complete,
  input wire logic rx_read,
  output logic framing_error_flag,
  output logic receive_overrun_flag,
  output logic parity_error_flag,
  output logic master_spi_operation,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic serial_in
);
  import umspi_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_LEAD, S_TRAIL} umspi_state_e;
  typedef struct packed {
    umspi_state_e state;
    logic [11:0] div;
    logic [11:0] presc;
    logic [7:0] sh_tx;
    logic [7:0] sh_rx;
    logic [3:0] bitn;
    logic sck;
    logic sdo;
    logic txc;
  } umspi_st_s;

  umspi_st_s st_ff, nxt_st;
  logic tick, mspi, tx_on, rx_on;
  logic txq_valid, txq_ready, rxq_in_valid, rxq_in_ready, rxq_valid;
  logic in_bit;
  logic [7:0] rx_word;
  logic [7:0] txq_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode
  // Control inputs shared by all modes
  assign mspi = operating_mode_select_field == MODE_MSPI;
  assign master_spi_operation = mspi;
  assign tx_on = mspi && transmitter_enable_bit;
  assign rx_on = mspi && receiver_enable_bit;

  assign framing_error_flag = 1'b0;
  assign receive_overrun_flag = 1'b0;
  assign parity_error_flag = 1'b0;

  assign transfer_clock_pin_oe = mspi && clock_pin_direction_bit;
  assign transfer_clock_pin_o = st_ff.sck;
  // Transmitter overrides the output pin only when enabled
  assign serial_out_oe = tx_on;
  assign serial_out = st_ff.sdo;

  // Half-bit tick: prescaler at zero, reloaded from divisor
  assign tick = st_ff.presc == 12'h000;

  umspi_buf2 #(.W(8)) u_txq (
    .mclk(mclk),
    .rst(rst),
    .flush(!mspi),
    .in_valid(tx_write && tx_on),
    .in_ready(tx_buffer_empty),
    .in_data(tx_data),
    .out_valid(txq_valid),
    .out_ready(txq_ready),
    .out_data(txq_data)
  );

  // Receive queue: when full, the last byte is dropped, not the oldest
  umspi_buf2 #(.W(8)) u_rxq (
    .mclk(mclk),
    .rst(rst),
    .flush(!rx_on),
    .in_valid(rxq_in_valid),
    .in_ready(rxq_in_ready),
    .in_data(rx_word),
    .out_valid(rxq_valid),
    .out_ready(rx_read),
    .out_data(rx_data)
  );
  assign rx_complete = rxq_valid;
  assign tx_complete = st_ff.txc;

  // Incoming bit lands at order-specific end
  assign in_bit = serial_in;
  assign rx_word = st_ff.sh_rx;

  assign txq_ready = (st_ff.state == S_IDLE) && tx_on;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared transfer controller
  always_comb begin
    nxt_st = st_ff;
    // Twelve-bit divisor, loaded on low write
    if (baud_divisor_low_wr) begin
      nxt_st.div = {baud_divisor_high, baud_divisor_low};
      nxt_st.presc = {baud_divisor_high, baud_divisor_low};
    end else if (tick) begin
      nxt_st.presc = st_ff.div;
    end else begin
      nxt_st.presc = st_ff.presc - 12'h001;
    end
    // Async flow never runs in this mode; tx complete sticks until cleared
    if (tx_complete_clr) begin
      nxt_st.txc = 1'b0;
    end
    case (st_ff.state)
      S_IDLE: begin
        nxt_st.sck = clock_polarity_bit;
        // A queued byte starts a transfer
        if (txq_valid && tx_on) begin
          nxt_st.sh_tx = txq_data;
          nxt_st.bitn = 4'h0;
          nxt_st.state = S_LEAD;
          if (clock_phase_bit) begin
            nxt_st.sdo = st_ff.sdo;
          end else begin
            nxt_st.sdo = bit_order_select ? txq_data[0] : txq_data[7];
          end
          nxt_st.presc = st_ff.div;
        end
      end
      S_LEAD: begin
        if (tick) begin
          nxt_st.sck = ~clock_polarity_bit;
          // Phase picks sample or setup here
          if (clock_phase_bit) begin
            nxt_st.sdo = bit_order_select ? st_ff.sh_tx[0] : st_ff.sh_tx[7];
          end else begin
            nxt_st.sh_rx = bit_order_select ? {in_bit, st_ff.sh_rx[7:1]} : {st_ff.sh_rx[6:0], in_bit};
          end
          nxt_st.state = S_TRAIL;
        end
      end
      S_TRAIL: begin
        if (tick) begin
          nxt_st.sck = clock_polarity_bit;
          nxt_st.sh_tx = bit_order_select ? {1'b0, st_ff.sh_tx[7:1]} : {st_ff.sh_tx[6:0], 1'b0};
          if (clock_phase_bit) begin
            nxt_st.sh_rx = bit_order_select ? {in_bit, st_ff.sh_rx[7:1]} : {st_ff.sh_rx[6:0], in_bit};
          end else if (st_ff.bitn != BIT_LAST) begin
            nxt_st.sdo = bit_order_select ? st_ff.sh_tx[1] : st_ff.sh_tx[6];
          end
          if (st_ff.bitn == BIT_LAST) begin
            nxt_st.state = S_IDLE;
            nxt_st.txc = 1'b1;
          end else begin
            nxt_st.bitn = st_ff.bitn + 4'h1;
            nxt_st.state = S_LEAD;
          end
        end
      end
      default: begin
        nxt_st.state = S_IDLE;
      end
    endcase
    if (!tx_on) begin
      nxt_st.state = S_IDLE;
      nxt_st.sck = clock_polarity_bit;
    end
  end

  // Received word enters queue at frame end
  logic frame_done_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= (st_ff.state == S_TRAIL) && tick && (st_ff.bitn == BIT_LAST) && tx_on;
    end
  end
  always_comb begin
    rxq_in_valid = frame_done_ff && rx_on;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '{state: S_IDLE, div: DIV_RESET, presc: DIV_RESET, sh_tx: 8'h00, sh_rx: 8'h00,
                 bitn: 4'h0, sck: 1'b0, sdo: 1'b1, txc: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  flags_zero_a: assert property (@(posedge mclk) disable iff (rst)
    !framing_error_flag && !receive_overrun_flag && !parity_error_flag)
    else $error("error flag not zero");
  idle_level_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_IDLE) && $past(st_ff.state == S_IDLE) && $stable(clock_polarity_bit)
    |-> transfer_clock_pin_o == clock_polarity_bit)
    else $error("idle clock level wrong");
  lead_edge_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_LEAD) && tick && tx_on |=> transfer_clock_pin_o == !$past(clock_polarity_bit))
    else $error("leading edge wrong");
  half_period_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_LEAD) && tick && tx_on && !baud_divisor_low_wr && st_ff.div == 12'h000
    |=> tick)
    else $error("divisor zero not half clock");
  mode_gate_a: assert property (@(posedge mclk) disable iff (rst)
    !mspi |=> st_ff.state == S_IDLE)
    else $error("transfer outside master mode");
  frame_len_a: assert property (@(posedge mclk) disable iff (rst)
    st_ff.state != S_IDLE |-> st_ff.bitn <= BIT_LAST)
    else $error("frame longer than eight");
  txc_set_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_TRAIL) && tick && st_ff.bitn == BIT_LAST && tx_on |=> tx_complete)
    else $error("complete not set at frame end");
  clk_drive_a: assert property (@(posedge mclk) disable iff (rst)
    transfer_clock_pin_oe |-> mspi)
    else $error("clock driven outside mode");

  ////////////////////////////////////////////////////////////////////////////////
  // Watch logic: cycles each clock level has stood so far
  // Restarts as the pin moves; a divisor write mid-level spoils that measure
  logic [12:0] hp_cnt_ff;
  logic hp_clean_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hp_cnt_ff <= 13'h0000;
      hp_clean_ff <= 1'b0;
    end else if (nxt_st.sck != st_ff.sck) begin
      hp_cnt_ff <= 13'h0000;
      hp_clean_ff <= 1'b1;
    end else begin
      if (hp_cnt_ff != 13'h1FFF) begin
        hp_cnt_ff <= hp_cnt_ff + 13'h0001;
      end
      if (baud_divisor_low_wr) begin
        hp_clean_ff <= 1'b0;
      end
    end
  end
  half_level_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_TRAIL || (st_ff.state == S_LEAD && st_ff.bitn != 4'h0)) && tick && tx_on
    && hp_clean_ff && !baud_divisor_low_wr |-> hp_cnt_ff == {1'b0, st_ff.div})
    else $error("half period length wrong");

  // Clock edges and data setup per phase
  trail_edge_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_TRAIL) && tick && tx_on |=> transfer_clock_pin_o == $past(clock_polarity_bit))
    else $error("trailing edge wrong");
  lead_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_LEAD) && tick && tx_on && !clock_phase_bit |=> $stable(serial_out))
    else $error("data moved on sampling edge");
  trail_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_TRAIL) && tick && tx_on && clock_phase_bit |=> $stable(serial_out))
    else $error("data moved on sampling edge");
  first_bit_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_IDLE) && txq_valid && tx_on && !clock_phase_bit
    |=> serial_out == ($past(bit_order_select) ? $past(txq_data[0]) : $past(txq_data[7])))
    else $error("first bit order wrong");
  idle_disable_a: assert property (@(posedge mclk) disable iff (rst)
    !tx_on |=> transfer_clock_pin_o == $past(clock_polarity_bit))
    else $error("disabled clock not idle");

  // Transfer start, frame end and flags
  queue_start_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff.state == S_IDLE) && txq_valid && tx_on |=> st_ff.state == S_LEAD)
    else $error("queued byte not started");
  eight_bits_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(tx_complete) |-> $past(st_ff.bitn) == BIT_LAST)
    else $error("frame ended early");
  txc_clear_a: assert property (@(posedge mclk) disable iff (rst)
    tx_complete_clr && !((st_ff.state == S_TRAIL) && tick && (st_ff.bitn == BIT_LAST) && tx_on)
    |=> !tx_complete)
    else $error("complete flag not cleared");
  div_load_a: assert property (@(posedge mclk) disable iff (rst)
    baud_divisor_low_wr |=> st_ff.div == {$past(baud_divisor_high), $past(baud_divisor_low)})
    else $error("divisor not loaded");
  tx_pin_a: assert property (@(posedge mclk) disable iff (rst)
    serial_out_oe |-> mspi && transmitter_enable_bit)
    else $error("data pin driven while disabled");

  // Receive path: a full queue keeps its oldest byte
  rx_capture_a: assert property (@(posedge mclk) disable iff (rst)
    rxq_in_valid && rxq_in_ready |=> rx_complete)
    else $error("received byte not queued");
  rx_keep_a: assert property (@(posedge mclk) disable iff (rst)
    rxq_in_valid && !rxq_in_ready && !rx_read |=> $stable(rx_data))
    else $error("full queue lost oldest byte");

  // Cover points
  start_cov: cover property (@(posedge mclk) disable iff (rst) txq_ready && txq_valid);
  mode3_cov: cover property (@(posedge mclk) disable iff (rst) frame_done_ff && clock_polarity_bit && clock_phase_bit);
  queued_cov: cover property (@(posedge mclk) disable iff (rst) st_ff.state != S_IDLE && !tx_buffer_empty);
  mode1_cov: cover property (@(posedge mclk) disable iff (rst) frame_done_ff && !clock_polarity_bit && clock_phase_bit);
  rx_drop_cov: cover property (@(posedge mclk) disable iff (rst) rxq_in_valid && !rxq_in_ready);
endmodule : umspi_master

// *** bench/umspi_slave.sv ***
// Purpose: Behavioural SPI slave on the far side of the master
// Assumes: Clock stands still between frames; bench calls sync after a mode change
// Notes: Reply to frame n is 5A plus n; with cpha set, a released data line shows its inverse
`timescale 1ns/1ns
module umspi_slave (
  input wire logic sck,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] sh = 8'h00;
  logic [7:0] got_q[$];
  logic [7:0] n = 8'h00;
  int s = 0;
  initial miso = 1'b0;
  function automatic logic bitv(input int k);
    logic [7:0] r;
    r = 8'h5A + n;
    return lsb ? r[k] : r[7-k];
  endfunction : bitv
  // Idle level changes on a mode switch would look like edges
  task automatic sync;
    s = 0;
    miso = cpha ? ~miso : bitv(0);
  endtask : sync
  ////////////////////////////////////////////////////////////
  // edge roles, eight bits
  always @(sck) begin
    if ((sck !== cpol) != cpha) begin
      sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      s++;
      if (s == 8) begin
        got_q.push_back(sh);
        n++;
        s = 0;
        if (cpha) miso = ~miso;
      end
    end else miso = bitv(s);
  end
endmodule : umspi_slave

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the master SPI block
// Assumes: Slave model on the three wires
// Notes: Small divisors keep frames short
`timescale 1ns/1ns
module tb;
  import umspi_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, txen = 1'b0, rxen = 1'b0, dir = 1'b0;
  logic [3:0] dh = 4'h0;
  logic [7:0] dl = 8'h00, txd = 8'h00, nf = 8'h00;
  logic dwr = 1'b0, txw = 1'b0, txclr = 1'b0, rxr = 1'b0;
  wire logic txe, txc, rxc, fe, ov, pe, msp, sck, sck_oe, sdo, sdo_oe, miso;
  wire logic [7:0] rxd;
  int failures = 0;
  int checks_done = 0;
  initial forever #25 mclk = ~mclk;
  umspi_master umspi_master_i (.mclk(mclk), .rst(rst), .operating_mode_select_field(mode),
    .clock_polarity_bit(cpol), .clock_phase_bit(cpha), .bit_order_select(lsb), .transmitter_enable_bit(txen),
    .receiver_enable_bit(rxen), .clock_pin_direction_bit(dir), .baud_divisor_high(dh), .baud_divisor_low(dl),
    .baud_divisor_low_wr(dwr), .tx_data(txd), .tx_write(txw), .tx_buffer_empty(txe), .tx_complete(txc),
    .tx_complete_clr(txclr), .rx_data(rxd), .rx_complete(rxc), .rx_read(rxr), .framing_error_flag(fe),
    .receive_overrun_flag(ov), .parity_error_flag(pe), .master_spi_operation(msp), .transfer_clock_pin_o(sck),
    .transfer_clock_pin_oe(sck_oe), .serial_out(sdo), .serial_out_oe(sdo_oe), .serial_in(miso));
  umspi_slave umspi_slave_i (.sck(sck), .cpol(cpol), .cpha(cpha), .lsb(lsb), .mosi(sdo), .miso(miso));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  function automatic logic sel(input int w);
    return w == 0 ? txe : (w == 1 ? rxc : (umspi_slave_i.got_q.size() > 2));
  endfunction : sel
  task automatic wait_hi(input int w);
    int i;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (sel(w) !== 1'b1 && i < 20000);
    if (i >= 20000) begin
      failures++;
      conclude();
    end
  endtask : wait_hi
  task automatic send(input logic [7:0] b);
    wait_hi(0);
    @(posedge mclk);
    txd <= b;
    txw <= 1'b1;
    @(posedge mclk);
    txw <= 1'b0;
  endtask : send
  task automatic recv;
    wait_hi(1);
    check("rx_data", {8'h00, rxd}, {8'h00, 8'h5A + nf});
    nf++;
    @(posedge mclk);
    rxr <= 1'b1;
    @(posedge mclk);
    rxr <= 1'b0;
  endtask : recv
  task automatic setdiv(input logic [11:0] d);
    @(posedge mclk);
    dh <= d[11:8];
    dl <= d[7:0];
    dwr <= 1'b1;
    @(posedge mclk);
    dwr <= 1'b0;
  endtask : setdiv
  ////////////////////////////////////////////////////////////
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      mode <= 2'(m);
      @(negedge mclk);
      check("mspi", {15'h0, msp}, {15'h0, m == 3});
      check("sck_oe", {15'h0, sck_oe}, {15'h0, m == 3});
    end
  endtask : t_mode
  // polarity and phase change only between frames
  task automatic t_xfer(input logic p, input logic h, input logic l, input logic [7:0] b);
    @(posedge mclk);
    cpol <= p;
    cpha <= h;
    lsb <= l;
    repeat (4) @(posedge mclk);
    umspi_slave_i.sync();
    send(b);
    recv();
    check("slave_rx", {8'h00, umspi_slave_i.got_q.pop_front()}, {8'h00, b});
    check("sck_idle", {15'h0, sck}, {15'h0, p});
    check("sdo_oe", {15'h0, sdo_oe}, 16'h0001);
  endtask : t_xfer
  task automatic t_rate(input logic [11:0] d);
    int n;
    setdiv(d);
    send(8'hC3);
    for (n = 0; n < 9000 && sck === cpol; n++) @(negedge mclk);
    for (n = 0; n < 9000 && sck !== cpol; n++) @(negedge mclk);
    check("half_period", 16'(n), {4'h0, d} + 16'h0001);
    recv();
    void'(umspi_slave_i.got_q.pop_front());
  endtask : t_rate
  task automatic t_queue;
    setdiv(12'h001);
    send(8'hAA);
    send(8'h55);
    send(8'h0F);
    @(negedge mclk);
    check("tx_full", {15'h0, txe}, 16'h0000);
    @(posedge mclk);
    txd <= 8'hFF;
    txw <= 1'b1;
    @(posedge mclk);
    txw <= 1'b0;
    wait_hi(2);
    repeat (40) @(negedge mclk);
    check("frames", 16'(umspi_slave_i.got_q.size()), 16'h0003);
    check("tx_done", {15'h0, txc}, 16'h0001);
    check("flags", {13'h0, fe, ov, pe}, 16'h0000);
    recv();
    recv();
    nf++;
    @(posedge mclk);
    rxen <= 1'b0;
    txclr <= 1'b1;
    @(posedge mclk);
    rxen <= 1'b1;
    txclr <= 1'b0;
    @(negedge mclk);
    check("rx_flushed", {15'h0, rxc}, 16'h0000);
    check("tx_cleared", {15'h0, txc}, 16'h0000);
  endtask : t_queue
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("reset", {13'h0, sck, txe, rxc}, 16'h0002);
    // clock pin set as output first
    @(posedge mclk);
    dir <= 1'b1;
    t_mode();
    @(posedge mclk);
    txen <= 1'b1;
    rxen <= 1'b1;
    setdiv(12'h002);
    t_xfer(1'b0, 1'b0, 1'b0, 8'h96);
    t_xfer(1'b0, 1'b1, 1'b1, 8'h3C);
    t_xfer(1'b1, 1'b0, 1'b1, 8'hE1);
    t_xfer(1'b1, 1'b1, 1'b0, 8'h4B);
    t_rate(12'h000);
    t_rate(12'h102);
    t_queue();
    conclude();
  end
endmodule : tb
